//--- logic/cfr_pkg.sv
// Package: constants, opcodes and carriers for the condition flag register
package cfr_pkg;
  localparam int CFR_W        = 32;
  localparam int CFR_FIELDS   = 8;
  localparam int CFR_FIELD_W  = 4;
  // Bit positions inside a field, bit 0 is the field's most significant bit
  localparam int FLD_LESS     = 0;
  localparam int FLD_GREATER  = 1;
  localparam int FLD_EQUAL    = 2;
  localparam int FLD_SUMMARY  = 3;
  localparam logic [2:0] INT_RESULT_FIELD   = 3'h0;
  localparam logic [2:0] FLOAT_STATUS_FIELD = 3'h1;
  // Integer exception register positions (bit 0 is msb)
  localparam int XER_SO_POS = 0;
  localparam int XER_OV_POS = 1;
  localparam int XER_CA_POS = 2;
  // Float status positions (bit 0 is msb)
  localparam int FS_VX_POS    = 2;
  localparam int FS_VXSNAN    = 7;
  localparam int FS_VXVC      = 12;
  localparam int FS_VXSOFT    = 21;
  localparam int FS_VXCVI     = 23;
  localparam int FS_CLASS_POS = 15;
  // Result class codes, C then less, greater, equal, unordered
  localparam logic [4:0] CLS_QNAN     = 5'h11;
  localparam logic [4:0] CLS_NEG_INF  = 5'h09;
  localparam logic [4:0] CLS_NEG_NORM = 5'h08;
  localparam logic [4:0] CLS_NEG_DEN  = 5'h18;
  localparam logic [4:0] CLS_NEG_ZERO = 5'h12;
  localparam logic [4:0] CLS_POS_ZERO = 5'h02;
  localparam logic [4:0] CLS_POS_DEN  = 5'h14;
  localparam logic [4:0] CLS_POS_NORM = 5'h04;
  localparam logic [4:0] CLS_POS_INF  = 5'h05;

  typedef enum logic [3:0] {
    CFR_OP_NONE,
    CFR_OP_MOVE_GPR,
    CFR_OP_COPY_FIELD,
    CFR_OP_MOVE_FPSTAT,
    CFR_OP_MOVE_XER,
    CFR_OP_LOGIC,
    CFR_OP_INT_RECORD,
    CFR_OP_FP_RECORD,
    CFR_OP_INT_CMP,
    CFR_OP_FP_CMP
  } cfr_op_t;

  typedef enum logic [2:0] {
    CFR_LOG_AND,
    CFR_LOG_OR,
    CFR_LOG_XOR,
    CFR_LOG_NAND,
    CFR_LOG_NOR,
    CFR_LOG_EQV,
    CFR_LOG_ANDC,
    CFR_LOG_ORC
  } cfr_logic_t;

  // One completing instruction's request to the flag register
  typedef struct packed {
    logic       valid;
    cfr_op_t    op;
    logic [7:0] field_mask;
    logic [2:0] dst_field;
    logic [2:0] src_field;
    logic [2:0] fp_group;
    logic [4:0] bit_a;
    logic [4:0] bit_b;
    logic [4:0] bit_d;
    cfr_logic_t log_op;
    logic       cmp_signed;
    logic       result_undef;
    logic [31:0] opnd_a;
    logic [31:0] opnd_b;
  } cfr_req_t;

  // Floating-point compare outcome from the float unit
  typedef struct packed {
    logic less;
    logic greater;
    logic equal;
    logic unordered;
  } cfr_fpcmp_t;
endpackage : cfr_pkg

//--- logic/cfr_flags.sv
// Condition flag register with its update paths and branch test port
`timescale 1ns/10ps
// Contract
// - 32 bits as eight 4-bit fields, field0 msb
// - move from gpr writes mask-selected fields
// - copy one whole field into another
// - load field from float status group
// - load field from integer exception bits
// - logical op on single flag bits
// - compare writes named field; bits testable
// - record integer sets field0 signed, summary
// - field0: negative, positive, zero, summary overflow
// - undefined result may leave field0 undefined
// - float record copies status bits 0-3
// - field1 exception, enabled, invalid, overflow
// - compare less, greater, equal; signed or unsigned
// - compare bit3: summary or unordered
// - five-bit float result class encodings
// - summary overflow sticky until software clear
// - invalid summary is OR, not sticky
module cfr_flags
  import cfr_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire cfr_req_t         req,
  input  wire logic             int_ov_set,
  input  wire logic             xer_so_clear,
  input  wire logic [31:0]      xer_value,
  input  wire logic [31:0]      float_status_control_reg_value,
  input  wire cfr_fpcmp_t       fp_cmp,
  input  wire logic [4:0]       test_bit,
  output logic [CFR_W-1:0]      condition_flags,
  output logic                  test_result,
  output logic                  summary_overflow,
  output logic [4:0]            fp_result_class_flags
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Field f, bit b (both counted from the msb) as a vector index
  function automatic int fidx(input logic [2:0] f, input int b);
    fidx = CFR_W - 1 - (int'(f) * CFR_FIELD_W + b);
  endfunction : fidx

  function automatic logic [3:0] get_field(input logic [31:0] v, input logic [2:0] f);
    get_field = v[CFR_W - 1 - int'(f) * CFR_FIELD_W -: CFR_FIELD_W];
  endfunction : get_field

  logic [CFR_W-1:0] flags_reg;
  logic [CFR_W-1:0] flags_next;
  logic             so_reg;
  logic             so_final;
  logic             fp_invalid_summary;
  logic [3:0]       fp_status_nibble;
  logic [3:0]       int_sign_field;
  logic [3:0]       cmp_field;
  logic             la;
  logic             lb;
  logic             lr;
  logic             cmp_lt;
  logic             cmp_gt;

  // ==========================================================
  // Summary overflow and float invalid summary
  // ==========================================================
  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      so_reg <= 1'b0;
    else if (int_ov_set)
      so_reg <= 1'b1;
    else if (xer_so_clear)
      so_reg <= 1'b0;
  end

  // Final state as the instruction completes includes this cycle's set
  assign so_final = so_reg | int_ov_set;

  // Recomputed every use, never held
  assign fp_invalid_summary = |{float_status_control_reg_value[31-FS_VXSNAN -: 6], float_status_control_reg_value[31-FS_VXSOFT -: 3]};

  always_comb
  begin
    fp_status_nibble = float_status_control_reg_value[31:28];
    fp_status_nibble[3 - FS_VX_POS] = fp_invalid_summary;
  end

  // ==========================================================
  // Result sign and compare
  // ==========================================================
  always_comb
  begin
    int_sign_field = {$signed(req.opnd_a) < 0, $signed(req.opnd_a) > 0,
                      req.opnd_a == 32'h0000_0000, so_final};
    if (req.cmp_signed)
    begin
      cmp_lt = $signed(req.opnd_a) < $signed(req.opnd_b);
      cmp_gt = $signed(req.opnd_a) > $signed(req.opnd_b);
    end
    else
    begin
      cmp_lt = req.opnd_a < req.opnd_b;
      cmp_gt = req.opnd_a > req.opnd_b;
    end
    if (req.op == CFR_OP_FP_CMP)
      cmp_field = {fp_cmp.less, fp_cmp.greater, fp_cmp.equal, fp_cmp.unordered};
    else
      cmp_field = {cmp_lt, cmp_gt, req.opnd_a == req.opnd_b, so_final};
  end

  // ==========================================================
  // Next value
  // ==========================================================
  always_comb
  begin
    flags_next = flags_reg;
    la = flags_reg[31 - int'(req.bit_a)];
    lb = flags_reg[31 - int'(req.bit_b)];
    case (req.log_op)
      CFR_LOG_AND:  lr = la & lb;
      CFR_LOG_OR:   lr = la | lb;
      CFR_LOG_XOR:  lr = la ^ lb;
      CFR_LOG_NAND: lr = ~(la & lb);
      CFR_LOG_NOR:  lr = ~(la | lb);
      CFR_LOG_EQV:  lr = ~(la ^ lb);
      CFR_LOG_ANDC: lr = la & ~lb;
      CFR_LOG_ORC:  lr = la | ~lb;
      default:      lr = 1'b0;
    endcase
    if (req.valid)
    begin
      case (req.op)
        CFR_OP_MOVE_GPR:
          for (int f = 0; f < CFR_FIELDS; f++)
            if (req.field_mask[7 - f])
              flags_next[31 - f*4 -: 4] = req.opnd_a[31 - f*4 -: 4];
        CFR_OP_COPY_FIELD:
          flags_next[fidx(req.dst_field, 0) -: 4] = get_field(flags_reg, req.src_field);
        CFR_OP_MOVE_FPSTAT:
        begin
          flags_next[fidx(req.dst_field, 0) -: 4] =
            (req.fp_group == 3'h0) ? fp_status_nibble
                                   : get_field(float_status_control_reg_value, req.fp_group);
        end
        CFR_OP_MOVE_XER:
          flags_next[fidx(req.dst_field, 0) -: 4] =
            {so_final, xer_value[31-XER_OV_POS], xer_value[31-XER_CA_POS], 1'b0};
        CFR_OP_LOGIC:
          flags_next[31 - int'(req.bit_d)] = lr;
        CFR_OP_INT_RECORD:
        begin
          // Undefined results keep the old sign bits, which is allowed
          if (req.result_undef)
            flags_next[fidx(INT_RESULT_FIELD, FLD_SUMMARY)] = so_final;
          else
            flags_next[31 -: 4] = int_sign_field;
        end
        CFR_OP_FP_RECORD:
          flags_next[fidx(FLOAT_STATUS_FIELD, 0) -: 4] = fp_status_nibble;
        CFR_OP_INT_CMP,
        CFR_OP_FP_CMP:
          flags_next[fidx(req.dst_field, 0) -: 4] = cmp_field;
        default:
          flags_next = flags_reg;
      endcase
    end
  end

  // No reset: contents survive a reset
  always_ff @(posedge clk_sys)
  begin
    flags_reg <= flags_next;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      test_result <= 1'b0;
    else
      test_result <= flags_next[31 - int'(test_bit)];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      fp_result_class_flags <= CLS_POS_ZERO;
    else
      fp_result_class_flags <= float_status_control_reg_value[31-FS_CLASS_POS -: 5];
  end

  assign condition_flags  = flags_reg;
  assign summary_overflow = so_reg;

  // ==========================================================
  // Checks
  // ==========================================================
  move_gpr_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req.valid && req.op == CFR_OP_MOVE_GPR && req.field_mask == 8'hFF)
      |=> condition_flags == $past(req.opnd_a))
    else $error("full mask move did not load flags");
  copy_keep_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req.valid && req.op == CFR_OP_COPY_FIELD)
      |=> get_field(condition_flags, $past(req.dst_field))
          == get_field($past(condition_flags), $past(req.src_field)))
    else $error("field copy wrong");
  idle_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    !req.valid |=> $stable(condition_flags))
    else $error("flags changed without request");
  so_sticky_a: assert property (@(posedge clk_sys) disable iff (srst)
    (summary_overflow && !xer_so_clear) |=> summary_overflow)
    else $error("summary overflow dropped");
  so_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    int_ov_set |=> summary_overflow)
    else $error("overflow did not set summary");
  zero_rec_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req.valid && req.op == CFR_OP_INT_RECORD && !req.result_undef && req.opnd_a == 32'h0)
      |=> condition_flags[31:29] == 3'b001)
    else $error("zero result flags wrong");
  fp_rec_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req.valid && req.op == CFR_OP_FP_RECORD)
      |=> condition_flags[27:24] == $past(fp_status_nibble))
    else $error("float record field wrong");
  ucmp_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req.valid && req.op == CFR_OP_INT_CMP && !req.cmp_signed && req.opnd_a < req.opnd_b)
      |=> condition_flags[fidx($past(req.dst_field), FLD_LESS)])
    else $error("unsigned less not set");
  fpcmp_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req.valid && req.op == CFR_OP_FP_CMP && fp_cmp.unordered)
      |=> condition_flags[fidx($past(req.dst_field), FLD_SUMMARY)])
    else $error("unordered not recorded");
endmodule : cfr_flags

//--- bench/cfr_exec_model.sv
// Far-side model: execution units presenting exception, status and compare state
`timescale 1ns/10ps
module cfr_exec_model
  import cfr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        ld,
  input  wire logic [31:0] xer_in,
  input  wire logic [31:0] fps_in,
  input  wire cfr_fpcmp_t  cmp_in,
  output logic [31:0]      xer_value,
  output logic [31:0]      float_status_control_reg_value,
  output cfr_fpcmp_t       fp_cmp
);
  // ==========================================
  // Status loads whole, as a completing unit would present it
  always_ff @(posedge clk_sys)
  begin
    if (ld)
    begin
      xer_value   <= xer_in;
      float_status_control_reg_value <= fps_in;
      fp_cmp      <= cmp_in;
    end
  end
endmodule : cfr_exec_model

//--- bench/tb_top.sv
// Self-checking bench for the condition flag register
`timescale 1ns/10ps
module tb_top;
  import cfr_pkg::*;
  logic        clk_sys, srst, int_ov_set, xer_so_clear, ld, test_result, summary_overflow;
  logic [31:0] xer_value, float_status_control_reg_value, xer_in, fps_in, condition_flags;
  logic [4:0]  test_bit, fp_result_class_flags;
  cfr_req_t    req, nx;
  cfr_fpcmp_t  fp_cmp, cmp_in;
  int          failures, cmp_count;
  cfr_flags cfr_flags_i (.clk_sys(clk_sys), .srst(srst), .req(req), .int_ov_set(int_ov_set),
    .xer_so_clear(xer_so_clear), .xer_value(xer_value), .float_status_control_reg_value(float_status_control_reg_value),
    .fp_cmp(fp_cmp), .test_bit(test_bit), .condition_flags(condition_flags),
    .test_result(test_result), .summary_overflow(summary_overflow),
    .fp_result_class_flags(fp_result_class_flags));
  cfr_exec_model cfr_exec_model_i (.clk_sys(clk_sys), .ld(ld), .xer_in(xer_in),
    .fps_in(fps_in), .cmp_in(cmp_in), .xer_value(xer_value), .float_status_control_reg_value(float_status_control_reg_value),
    .fp_cmp(fp_cmp));
  // ==========================================
  // Shared tasks
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function logic [3:0] fld(input int f);
    fld = condition_flags[31-4*f -: 4];
  endfunction : fld
  // One completing instruction, one cycle wide
  task send();
    @(negedge clk_sys);
    req = nx;
    req.valid = 1'b1;
    // First request rides the reset release, so unwritten flags never sit idle
    srst = 1'b0;
    @(negedge clk_sys);
    req.valid = 1'b0;
    nx = '0;
  endtask : send
  task env(input logic [31:0] x, input logic [31:0] f, input cfr_fpcmp_t c);
    @(negedge clk_sys);
    xer_in = x;
    fps_in = f;
    cmp_in = c;
    ld = 1'b1;
    @(negedge clk_sys);
    ld = 1'b0;
  endtask : env
  task pulse(input bit ov);
    @(negedge clk_sys);
    if (ov) int_ov_set = 1'b1;
    else xer_so_clear = 1'b1;
    @(negedge clk_sys);
    int_ov_set = 1'b0;
    xer_so_clear = 1'b0;
  endtask : pulse
  task wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  // ==========================================
  // Scenarios
  task t_move_copy();
    nx.op = CFR_OP_MOVE_GPR; nx.field_mask = 8'hFF; nx.opnd_a = 32'h12345678; send();
    chk(condition_flags, 32'h12345678);
    nx.op = CFR_OP_MOVE_GPR; nx.field_mask = 8'h81; nx.opnd_a = 32'hFFFFFFFF; send();
    chk(condition_flags, 32'hF234567F);
    nx.op = CFR_OP_COPY_FIELD; nx.src_field = 3'h1; nx.dst_field = 3'h6; send();
    chk(condition_flags, 32'hF234562F);
    @(negedge clk_sys) srst = 1'b1;
    @(negedge clk_sys) srst = 1'b0;
    chk(condition_flags, 32'hF234562F);
    $display("move and copy done");
  endtask : t_move_copy
  task t_compare();
    env(32'h0, 32'h0, 4'h1);
    test_bit = 5'h08;
    nx.op = CFR_OP_INT_CMP; nx.dst_field = 3'h2; nx.cmp_signed = 1'b1;
    nx.opnd_a = 32'hFFFFFFFF; nx.opnd_b = 32'h1; send();
    chk(fld(2), 4'h8);
    chk(test_result, 1'b1);
    nx.op = CFR_OP_INT_CMP; nx.dst_field = 3'h3; nx.opnd_a = 32'hFFFFFFFF; nx.opnd_b = 32'h1;
    send();
    chk(fld(3), 4'h4);
    nx.op = CFR_OP_INT_CMP; nx.dst_field = 3'h4; nx.opnd_a = 32'h1; nx.opnd_b = 32'hFFFFFFFF;
    send();
    chk(fld(4), 4'h8);
    nx.op = CFR_OP_FP_CMP; nx.dst_field = 3'h5; send();
    chk(fld(5), 4'h1);
    $display("compare done");
  endtask : t_compare
  task t_record();
    pulse(1'b1);
    chk(summary_overflow, 1'b1);
    nx.op = CFR_OP_INT_RECORD; nx.opnd_a = 32'h0; send();
    chk(fld(0), 4'h3);
    nx.op = CFR_OP_INT_RECORD; nx.opnd_a = 32'h5; send();
    chk(fld(0), 4'h5);
    pulse(1'b0);
    nx.op = CFR_OP_INT_RECORD; nx.opnd_a = 32'hFFFFFFF0; send();
    chk(fld(0), 4'h8);
    pulse(1'b1);
    nx.op = CFR_OP_INT_RECORD; nx.result_undef = 1'b1; nx.opnd_a = 32'h0; send();
    chk(fld(0), 4'h9);
    pulse(1'b0);
    chk(summary_overflow, 1'b0);
    $display("integer record done");
  endtask : t_record
  task t_float_xer();
    env(32'h60000000, 32'hB1000000 | (32'(CLS_QNAN) << 12), 4'h1);
    nx.op = CFR_OP_FP_RECORD; send();
    chk(fld(1), 4'hB);
    chk(fp_result_class_flags, CLS_QNAN);
    nx.op = CFR_OP_MOVE_FPSTAT; nx.dst_field = 3'h6; nx.fp_group = 3'h1; send();
    chk(fld(6), 4'h1);
    // Summary bit set with no invalid cause behind it must drop
    env(32'h60000000, 32'hA0000000, 4'h1);
    nx.op = CFR_OP_MOVE_FPSTAT; nx.dst_field = 3'h7; nx.fp_group = 3'h0; send();
    chk(fld(7), 4'h8);
    nx.op = CFR_OP_MOVE_XER; nx.dst_field = 3'h4; send();
    chk(fld(4), 4'h6);
    $display("float and exception moves done");
  endtask : t_float_xer
  task t_logic();
    logic [7:0] exp;
    exp = 8'hCE;
    nx.op = CFR_OP_MOVE_GPR; nx.field_mask = 8'hFF; nx.opnd_a = 32'h80000000; send();
    for (int i = 0; i < 8; i++)
    begin
      nx.op = CFR_OP_LOGIC; nx.bit_a = 5'h00; nx.bit_b = 5'h01; nx.bit_d = 5'h1F;
      nx.log_op = cfr_logic_t'(i); send();
      chk(condition_flags[0], exp[i]);
    end
    $display("logic done");
  endtask : t_logic
  initial
  begin
    {srst, int_ov_set, xer_so_clear, ld} = 4'h8;
    {req, nx, xer_in, fps_in, cmp_in, test_bit} = '0;
    failures = 0;
    cmp_count = 0;
    repeat (11) @(negedge clk_sys);
    t_move_copy();
    t_compare();
    t_record();
    t_float_xer();
    t_logic();
    wrap_up();
  end
  initial
  begin
    #200us;
    failures++;
    wrap_up();
  end
endmodule : tb_top
